/* File: sarc_pkg.sv */
// constants shared by the result and mode control block of the successive-approximation converter
// assumes a 10 MHz system clock and a byte-addressed register port with optional 16-bit access
package sarc_pkg;

	// -------------------------------------------------------------------
	// clock and conversion timing
	// -------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned CONV_FAST_NS = 13500; // needs the pll oscillation mode
	localparam int unsigned CONV_SLOW_NS = 43000;
	localparam int unsigned CONV_FAST_CYC = (CONV_FAST_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_FAST_NS / CLK_PERIOD_NS;
	localparam int unsigned CONV_SLOW_CYC = (CONV_SLOW_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_SLOW_NS / CLK_PERIOD_NS;
	localparam int unsigned CYC_W = 9;

	// -------------------------------------------------------------------
	// register map
	// -------------------------------------------------------------------
	localparam logic [15:0] CH7_RESULT_LOW_ADDR = 16'hF8DE;
	localparam logic [15:0] CH7_RESULT_HIGH_ADDR = 16'hF8DF;
	localparam logic [15:0] CH8_RESULT_LOW_ADDR = 16'hF8E0;
	localparam logic [15:0] CH8_RESULT_HIGH_ADDR = 16'hF8E1;
	localparam logic [15:0] CH9_RESULT_LOW_ADDR = 16'hF8E2;
	localparam logic [15:0] CH9_RESULT_HIGH_ADDR = 16'hF8E3;
	localparam logic [15:0] CH10_RESULT_LOW_ADDR = 16'hF8E4;
	localparam logic [15:0] CH10_RESULT_HIGH_ADDR = 16'hF8E5;
	localparam logic [15:0] CH11_RESULT_LOW_ADDR = 16'hF8E6;
	localparam logic [15:0] CH11_RESULT_HIGH_ADDR = 16'hF8E7;
	localparam logic [15:0] CONVERTER_CONTROL_ZERO_ADDR = 16'hF8F0;
	localparam logic [15:0] CONVERTER_CONTROL_ONE_ADDR = 16'hF8F1;
	localparam logic [15:0] CHANNEL_SELECT_LOW_ADDR = 16'hF8F2;
	localparam logic [15:0] CHANNEL_SELECT_HIGH_ADDR = 16'hF8F3;

	// -------------------------------------------------------------------
	// fields and reset values
	// -------------------------------------------------------------------
	localparam int unsigned REPEAT_SELECT_BIT = 0;
	localparam int unsigned CONV_TIME_SELECT_BIT = 1;
	localparam int unsigned CONVERSION_RUN_BIT = 0;
	localparam int unsigned RESULT_W = 10;
	localparam int unsigned CH_W = 4;
	localparam int unsigned NUM_CH = 12;
	localparam int unsigned NUM_RESULT_CH = 5;
	localparam logic [3:0] FIRST_RESULT_CH = 4'h7;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [1:0] CONTROL_RESET = 2'h0;
	localparam logic [3:0] SELECT_HIGH_RESET = 4'h0;
	localparam logic [9:0] RESULT_RESET = 10'h000;
	localparam int unsigned FIFO_DEPTH = 16;

	// -------------------------------------------------------------------
	// sequencer states
	// -------------------------------------------------------------------
	typedef enum logic [0:0] {
		SARC_IDLE = 1'b0,
		SARC_CONV = 1'b1
	} sarc_state_e;

endpackage : sarc_pkg

/* File: sarc_top.sv */
// result registers, mode control and channel sequencer of the successive-approximation converter
// assumes the analog core answers each start with one tagged result on a valid/ready stream
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------
// result fifo between the analog core and the result registers
// -------------------------------------------------------------------
// depth must be a power of two so the pointers wrap on their own
module sarc_fifo #(
	parameter int unsigned WIDTH = 14,
	parameter int unsigned DEPTH = 16
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic [AW:0] count_next;
	logic ready_reg;
	logic valid_reg;
	logic push;
	logic pop;

	// ready and valid are flops and are exactly the flags that decide the next edge's transfer
	assign push = in_valid_in && ready_reg;
	assign pop = valid_reg && out_ready_in;
	assign in_ready_out = ready_reg;
	assign out_valid_out = valid_reg;
	assign out_data_out = mem[rd_ptr_reg];

	// occupancy after this cycle's push and pop
	always_comb begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + (AW+1)'(1);
		end else if (pop && !push) begin
			count_next = count_reg - (AW+1)'(1);
		end
	end

	// storage needs no reset, only the pointers, count and flags do
	always_ff @(posedge clock_in) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end

	// pointers and flags
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			ready_reg <= 1'b0;
			valid_reg <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			end
			count_reg <= count_next;
			ready_reg <= (count_next != (AW+1)'(DEPTH));
			valid_reg <= (count_next != '0);
		end
	end
endmodule : sarc_fifo

// Operation
// - Bits 1 and 0 of each channel's 10-bit result sit in bits 7 and 6 of its low result register.
// - Bits 9 to 2 of each channel's result sit in bits 7 to 0 of its high result register.
// - A channel's result registers change only when a conversion on that channel completes.
// - Result registers are read-only, reset to zero, and low-register bits 5 to 0 read as zero.
// - A low result register reads as a byte or as a 16-bit word with its high partner; high ones are byte only.
// - With repeat select clear, which is its reset value, each selected channel is converted once per start.
// - With repeat select set, the selected channels are converted over and over until stopped.
// - With the conversion time bit clear, a channel takes about 13.5 us, valid only with the pll running.
// - With the conversion time bit set, a channel takes about 43 us.
// - Control register zero resets to zero, bits 7 to 2 read zero and only bits 1 and 0 are writable.
// - In single mode the run bit clears itself after the highest selected channel is done.
// - Selected channels are converted in ascending order starting at the lowest one.
// - A start with no channel selected leaves the run bit at zero and starts nothing.
module sarc_top #(
	parameter int unsigned FIFO_DEPTH_P = sarc_pkg::FIFO_DEPTH
) (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic [15:0] addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic wide_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [15:0] rdata_out,
	output logic core_start_out,
	output logic [sarc_pkg::CH_W-1:0] core_channel_out,
	output logic core_slow_out,
	input wire logic res_valid_in,
	output logic res_ready_out,
	input wire logic [sarc_pkg::CH_W-1:0] res_channel_in,
	input wire logic [sarc_pkg::RESULT_W-1:0] res_data_in
);
	import sarc_pkg::*;

	localparam int unsigned TAG_W = CH_W + RESULT_W;

	sarc_state_e state_reg;
	logic [1:0] control_reg;
	logic run_reg;
	logic [7:0] select_low_reg;
	logic [3:0] select_high_reg;
	logic [RESULT_W-1:0] result_reg [NUM_RESULT_CH];
	logic [CH_W-1:0] cur_reg;
	logic [CYC_W-1:0] cnt_reg;
	logic [CYC_W-1:0] limit_reg;
	logic [15:0] rd_word;
	logic [15:0] rel_addr;
	logic [2:0] rel_idx;
	logic [NUM_CH-1:0] sel;
	logic [CH_W:0] lowest;
	logic [CH_W:0] after;
	logic start_req;
	logic stop_req;
	logic conv_end;
	logic fifo_valid;
	logic fifo_ready;
	logic [TAG_W-1:0] fifo_data;
	logic [CH_W-1:0] drain_ch;
	logic [CH_W-1:0] drain_idx;
	logic [CYC_W-1:0] limit_now;

	// lowest selected channel at or above start; the top bit says one was found
	function automatic logic [CH_W:0] first_from(input logic [NUM_CH-1:0] s, input logic [CH_W:0] start);
		logic [CH_W:0] r;
		r = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (s[i] && (CH_W+1)'(i) >= start) begin
				r = {1'b1, CH_W'(i)};
			end
		end
		return r;
	endfunction : first_from

	// -------------------------------------------------------------------
	// register port decode
	// -------------------------------------------------------------------
	// a wide write at control zero also reaches the run bit next door
	assign sel = {select_high_reg, select_low_reg};
	assign start_req = wr_in && ((addr_in == CONVERTER_CONTROL_ONE_ADDR && wdata_in[CONVERSION_RUN_BIT])
		|| (wide_in && addr_in == CONVERTER_CONTROL_ZERO_ADDR && wdata_in[8 + CONVERSION_RUN_BIT]));
	assign stop_req = wr_in && ((addr_in == CONVERTER_CONTROL_ONE_ADDR && !wdata_in[CONVERSION_RUN_BIT])
		|| (wide_in && addr_in == CONVERTER_CONTROL_ZERO_ADDR && !wdata_in[8 + CONVERSION_RUN_BIT]));
	assign rel_addr = addr_in - CH7_RESULT_LOW_ADDR;
	assign rel_idx = rel_addr[3:1];
	assign lowest = first_from(sel, '0);
	assign after = first_from(sel, {1'b0, cur_reg} + (CH_W+1)'(1));
	assign conv_end = (state_reg == SARC_CONV) && (cnt_reg == limit_reg - CYC_W'(1));
	assign limit_now = control_reg[CONV_TIME_SELECT_BIT] ? CYC_W'(CONV_SLOW_CYC) : CYC_W'(CONV_FAST_CYC);

	// read mux: low byte packs bits 1:0 at the top, bits 5:0 read zero
	always_comb begin
		rd_word = 16'h0000;
		if (addr_in >= CH7_RESULT_LOW_ADDR && addr_in <= CH11_RESULT_HIGH_ADDR && rel_idx < 3'(NUM_RESULT_CH)) begin
			if (!rel_addr[0]) begin
				rd_word[7:0] = {result_reg[rel_idx][1:0], 6'h00};
				if (wide_in) begin
					rd_word[15:8] = result_reg[rel_idx][9:2];
				end
			end else begin
				rd_word[7:0] = result_reg[rel_idx][9:2];
			end
		end else if (addr_in == CONVERTER_CONTROL_ZERO_ADDR) begin
			rd_word[7:0] = {6'h00, control_reg};
			if (wide_in) begin
				rd_word[15:8] = {7'h00, run_reg};
			end
		end else if (addr_in == CONVERTER_CONTROL_ONE_ADDR) begin
			rd_word[7:0] = {7'h00, run_reg};
		end else if (addr_in == CHANNEL_SELECT_LOW_ADDR) begin
			rd_word[7:0] = select_low_reg;
		end else if (addr_in == CHANNEL_SELECT_HIGH_ADDR) begin
			rd_word[7:0] = {4'h0, select_high_reg};
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rdata_out <= 16'h0000;
		end else begin
			rdata_out <= rd_in ? rd_word : 16'h0000;
		end
	end

	// writable control and selection fields; result addresses ignore writes
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			control_reg <= CONTROL_RESET;
			select_low_reg <= REG_RESET;
			select_high_reg <= SELECT_HIGH_RESET;
		end else if (wr_in) begin
			if (addr_in == CONVERTER_CONTROL_ZERO_ADDR) begin
				control_reg <= wdata_in[1:0];
			end
			if (addr_in == CHANNEL_SELECT_LOW_ADDR) begin
				select_low_reg <= wdata_in[7:0];
			end
			if (addr_in == CHANNEL_SELECT_HIGH_ADDR) begin
				select_high_reg <= wdata_in[3:0];
			end
		end
	end

	// -------------------------------------------------------------------
	// channel sequencer
	// -------------------------------------------------------------------
	// the block times each channel itself; the core only samples and converts
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			state_reg <= SARC_IDLE;
			run_reg <= 1'b0;
			cur_reg <= '0;
			cnt_reg <= '0;
			limit_reg <= CYC_W'(CONV_FAST_CYC);
			core_start_out <= 1'b0;
			core_channel_out <= '0;
			core_slow_out <= 1'b0;
		end else begin
			core_start_out <= 1'b0;
			if (state_reg == SARC_IDLE) begin
				if (start_req && lowest[CH_W]) begin
					state_reg <= SARC_CONV;
					run_reg <= 1'b1;
					cur_reg <= lowest[CH_W-1:0];
					cnt_reg <= '0;
					limit_reg <= limit_now;
					core_start_out <= 1'b1;
					core_channel_out <= lowest[CH_W-1:0];
					core_slow_out <= control_reg[CONV_TIME_SELECT_BIT];
				end // an empty selection leaves run low
			end else if (stop_req) begin
				state_reg <= SARC_IDLE;
				run_reg <= 1'b0;
			end else if (conv_end) begin
				if (after[CH_W] || (control_reg[REPEAT_SELECT_BIT] && lowest[CH_W])) begin
					// next higher channel, or wrap to the lowest
					cur_reg <= after[CH_W] ? after[CH_W-1:0] : lowest[CH_W-1:0];
					core_channel_out <= after[CH_W] ? after[CH_W-1:0] : lowest[CH_W-1:0];
					cnt_reg <= '0;
					limit_reg <= limit_now;
					core_start_out <= 1'b1;
					core_slow_out <= control_reg[CONV_TIME_SELECT_BIT];
				end else begin
					state_reg <= SARC_IDLE;
					run_reg <= 1'b0;
				end
			end else begin
				cnt_reg <= cnt_reg + CYC_W'(1);
			end
		end
	end

	// -------------------------------------------------------------------
	// result path
	// -------------------------------------------------------------------
	// draining stalls during a bus read so a 16-bit read never tears
	assign fifo_ready = !rd_in;
	assign drain_ch = fifo_data[TAG_W-1:RESULT_W];
	assign drain_idx = drain_ch - FIRST_RESULT_CH;

	sarc_fifo #(
		.WIDTH(TAG_W),
		.DEPTH(FIFO_DEPTH_P)
	) u_fifo (
		.clock_in(clock_in),
		.arst_n_in(arst_n_in),
		.in_valid_in(res_valid_in),
		.in_ready_out(res_ready_out),
		.in_data_in({res_channel_in, res_data_in}),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_ready),
		.out_data_out(fifo_data)
	);

	// only a completed result for channels 7 to 11 touches these
	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			for (int i = 0; i < NUM_RESULT_CH; i++) begin
				result_reg[i] <= RESULT_RESET;
			end
		end else if (fifo_valid && fifo_ready && drain_ch >= FIRST_RESULT_CH
			&& drain_idx < CH_W'(NUM_RESULT_CH)) begin
			result_reg[drain_idx[2:0]] <= fifo_data[RESULT_W-1:0];
		end
	end

	// -------------------------------------------------------------------
	// assertions
	// -------------------------------------------------------------------
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);

	sequence s_chan_done;
		conv_end && !stop_req && !after[CH_W];
	endsequence

	sequence s_restart_low(logic [CH_W-1:0] ch);
		run_reg && core_start_out && core_channel_out == ch;
	endsequence

	a_low_pack: assert property (rd_in && !wide_in && addr_in == CH7_RESULT_LOW_ADDR
		|=> rdata_out == {8'h00, $past(result_reg[0][1:0]), 6'h00})
		else $error("low result byte packed wrongly");

	a_high_pack: assert property (rd_in && addr_in == CH11_RESULT_HIGH_ADDR
		|=> rdata_out == {8'h00, $past(result_reg[4][9:2])})
		else $error("high result byte packed wrongly");

	a_result_hold: assert property (!(fifo_valid && fifo_ready) |=> $stable(result_reg[1]))
		else $error("result changed without a completed conversion");

	a_result_load: assert property (fifo_valid && fifo_ready && drain_ch == FIRST_RESULT_CH
		|=> result_reg[0] == $past(fifo_data[RESULT_W-1:0]))
		else $error("completed result not stored");

	a_wide_read: assert property (rd_in && wide_in && addr_in == CH8_RESULT_LOW_ADDR
		|=> rdata_out == {$past(result_reg[1][9:2]), $past(result_reg[1][1:0]), 6'h00})
		else $error("wide result read wrong");

	a_ctl_zeros: assert property (rd_in && !wide_in && addr_in == CONVERTER_CONTROL_ZERO_ADDR
		|=> rdata_out[15:2] == 14'h0000 && rdata_out[1:0] == $past(control_reg))
		else $error("control zero read wrong");

	a_single_stop: assert property (s_chan_done ##0 !control_reg[REPEAT_SELECT_BIT]
		|=> !run_reg && state_reg == SARC_IDLE ##1 (!core_start_out || $past(start_req)))
		else $error("single sequence did not stop");

	a_repeat_wrap: assert property (s_chan_done ##0 control_reg[REPEAT_SELECT_BIT] && lowest[CH_W]
		|=> s_restart_low($past(lowest[CH_W-1:0])))
		else $error("repeat sequence did not wrap");

	a_ascend: assert property (conv_end && !stop_req && after[CH_W]
		|=> core_start_out && core_channel_out == $past(after[CH_W-1:0]) && core_channel_out > $past(cur_reg))
		else $error("channel order not ascending");

	a_first_low: assert property (state_reg == SARC_IDLE && start_req && lowest[CH_W]
		|=> s_restart_low($past(lowest[CH_W-1:0])))
		else $error("sequence did not begin at lowest channel");

	a_empty_start: assert property (state_reg == SARC_IDLE && start_req && sel == '0
		|=> !run_reg && !core_start_out)
		else $error("start with no channel selected ran");

	a_conv_time: assert property (core_start_out
		|-> limit_reg == (core_slow_out ? CYC_W'(CONV_SLOW_CYC) : CYC_W'(CONV_FAST_CYC)) && cnt_reg == '0)
		else $error("conversion time does not match select bit");

	a_conv_span: assert property (state_reg == SARC_CONV && !conv_end && !stop_req
		|=> !core_start_out && cnt_reg == $past(cnt_reg) + CYC_W'(1))
		else $error("conversion ended early");

endmodule : sarc_top

`default_nettype wire

/* File: sarc_core_model.sv */
// partner model of the analog conversion core: answers each start with one tagged result word
// assumes the sequencer pulses a start and the result stream takes a word on valid with ready seen
`timescale 1ns/1ps
`default_nettype none

// -------------------------------------------------------------------
// conversion core model
// -------------------------------------------------------------------
module sarc_core_model (
	input wire logic clock_in,
	input wire logic arst_n_in,
	input wire logic core_start_in,
	input wire logic [sarc_pkg::CH_W-1:0] core_channel_in,
	input wire logic res_ready_in,
	output logic res_valid_out,
	output logic [sarc_pkg::CH_W-1:0] res_channel_out,
	output logic [sarc_pkg::RESULT_W-1:0] res_data_out
);
	import sarc_pkg::*;
	int seed = 35624;
	logic [CH_W-1:0] ch_reg;

	initial begin
		res_valid_out = 1'b0;
		res_channel_out = '0;
		res_data_out = '0;
	end

	// one random word; valid, tag and value hold until ready is seen at an edge
	task automatic send(input logic [CH_W-1:0] ch);
		res_valid_out <= 1'b1;
		res_channel_out <= ch;
		res_data_out <= RESULT_W'($random(seed));
		@(posedge clock_in);
		while (res_ready_in !== 1'b1) begin
			@(posedge clock_in);
		end
	endtask : send

	// released data is scrambled so a stale value never passes for a fresh one
	task automatic idle_line;
		res_valid_out <= 1'b0;
		res_data_out <= ~res_data_out;
	endtask : idle_line

	// answer each start after a random delay, prompt or slow, inside one conversion slot
	always begin
		@(posedge clock_in);
		if (arst_n_in === 1'b1 && core_start_in === 1'b1) begin
			ch_reg = core_channel_in;
			repeat (1 + $unsigned($random(seed)) % 100) @(posedge clock_in);
			send(ch_reg);
			idle_line();
		end
	end
endmodule : sarc_core_model
`default_nettype wire

/* File: tb_sar_adc_results_and_mode_control.sv */
// self-checking bench for the converter result registers, mode control and channel sequencer
// assumes the core model answers every start; expectations come from the words it hands over
`timescale 1ns/1ps
`default_nettype none

module tb_sar_adc_results_and_mode_control;
	import sarc_pkg::*;
	logic clock_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [15:0] addr_in = '0;
	logic [15:0] wdata_in = '0;
	logic wide_in = 1'b0;
	logic wr_in = 1'b0;
	logic rd_in = 1'b0;
	logic [15:0] rdata_out;
	logic core_start_out;
	logic core_slow_out;
	logic res_valid_in;
	logic res_ready_out;
	logic [CH_W-1:0] core_channel_out;
	logic [CH_W-1:0] res_channel_in;
	logic [RESULT_W-1:0] res_data_in;
	logic [RESULT_W-1:0] exp_res [0:15];
	logic ready_low_seen = 1'b0;
	logic [15:0] q;
	int err_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int st_time[$];
	logic [CH_W-1:0] st_ch[$];
	logic st_slow[$];

	// -------------------------------------------------------------------
	// design, partner and clock
	// -------------------------------------------------------------------
	sarc_top #(.FIFO_DEPTH_P(16)) DUT (.clock_in(clock_in), .arst_n_in(arst_n_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wide_in(wide_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.core_start_out(core_start_out), .core_channel_out(core_channel_out), .core_slow_out(core_slow_out),
		.res_valid_in(res_valid_in), .res_ready_out(res_ready_out), .res_channel_in(res_channel_in),
		.res_data_in(res_data_in));
	sarc_core_model partner (.clock_in(clock_in), .arst_n_in(arst_n_in), .core_start_in(core_start_out),
		.core_channel_in(core_channel_out), .res_ready_in(res_ready_out), .res_valid_out(res_valid_in),
		.res_channel_out(res_channel_in), .res_data_out(res_data_in));

	initial begin
		forever #50 clock_in = ~clock_in;
	end

	// -------------------------------------------------------------------
	// monitor: accepted words, start pulses and the hang limit
	// -------------------------------------------------------------------
	always @(posedge clock_in) begin
		cyc++;
		if (arst_n_in === 1'b1 && res_valid_in === 1'b1 && res_ready_out === 1'b1) exp_res[res_channel_in] <= res_data_in;
		if (arst_n_in === 1'b1 && res_ready_out === 1'b0) ready_low_seen <= 1'b1;
		if (core_start_out === 1'b1) begin
			st_time.push_back(cyc);
			st_ch.push_back(core_channel_out);
			st_slow.push_back(core_slow_out);
		end
		if (cyc == 8000) begin
			err_count++;
			conclude();
		end
	end

	// -------------------------------------------------------------------
	// helpers
	// -------------------------------------------------------------------
	// wide image of a result: high byte bits 9..2, low byte bits 1..0 on top
	function automatic logic [15:0] word_exp(input logic [RESULT_W-1:0] v);
		return {v[9:2], v[1:0], 6'h00};
	endfunction : word_exp

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
		n_checks++;
		if (seen !== expv) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, expv, seen);
		end
	endtask : check

	// one strobe cycle; read data is taken in the cycle after the strobe
	task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic wd, output logic [15:0] rq);
		@(posedge clock_in);
		addr_in <= a;
		wdata_in <= d;
		wide_in <= wd;
		wr_in <= wr;
		rd_in <= ~wr;
		@(posedge clock_in);
		wr_in <= 1'b0;
		rd_in <= 1'b0;
		#1 rq = rdata_out;
	endtask : bus

	task automatic check_results;
		logic [15:0] a;
		logic [15:0] w;
		for (int c = 7; c <= 11; c++) begin
			a = CH7_RESULT_LOW_ADDR + 16'(2 * (c - 7));
			w = word_exp(exp_res[c]);
			bus(1'b0, a, 16'h0000, 1'b0, q);
			check("result low", q, {8'h00, w[7:0]});
			bus(1'b0, a + 16'h0001, 16'h0000, 1'b0, q);
			check("result high", q, {8'h00, w[15:8]});
			bus(1'b0, a, 16'h0000, 1'b1, q);
			check("result wide", q, w);
		end
	endtask : check_results

	task automatic check_starts(input int n, input int gap, input logic slow, input logic [3:0] chans [5]);
		check("start count", 16'(st_ch.size()), 16'(n));
		for (int i = 0; i < n && i < st_ch.size(); i++) begin
			check("start channel", {12'h000, st_ch[i]}, {12'h000, chans[i]});
			check("conversion speed", {15'h0000, st_slow[i]}, {15'h0000, slow});
			if (i > 0) check("start spacing", 16'(st_time[i] - st_time[i-1]), 16'(gap));
		end
		st_time.delete();
		st_ch.delete();
		st_slow.delete();
	endtask : check_starts

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	// -------------------------------------------------------------------
	// main sequence
	// -------------------------------------------------------------------
	initial begin
		for (int i = 0; i < 16; i++) exp_res[i] = '0;
		repeat (16) @(posedge clock_in);
		arst_n_in <= 1'b1;
		// reset values, control mask, ignored writes and an unmapped read
		check_results();
		bus(1'b0, CONVERTER_CONTROL_ZERO_ADDR, 16'h0000, 1'b0, q);
		check("control reset", q, 16'h0000);
		bus(1'b1, CONVERTER_CONTROL_ZERO_ADDR, 16'h00FF, 1'b0, q);
		bus(1'b0, CONVERTER_CONTROL_ZERO_ADDR, 16'h0000, 1'b0, q);
		check("control mask", q, 16'h0003);
		bus(1'b1, CH7_RESULT_LOW_ADDR, 16'hFFFF, 1'b1, q);
		bus(1'b1, CH11_RESULT_HIGH_ADDR, 16'h00FF, 1'b0, q);
		bus(1'b0, 16'hF8F8, 16'h0000, 1'b0, q);
		check("unmapped read", q, 16'h0000);
		check_results();
		// a start with no channel selected is refused
		bus(1'b1, CONVERTER_CONTROL_ZERO_ADDR, 16'h0000, 1'b0, q);
		bus(1'b1, CONVERTER_CONTROL_ONE_ADDR, 16'h0001, 1'b0, q);
		repeat (4) @(posedge clock_in);
		bus(1'b0, CONVERTER_CONTROL_ONE_ADDR, 16'h0000, 1'b0, q);
		check("run with no channel", q, 16'h0000);
		check_starts(0, 0, 1'b0, '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0});
		// single fast pass over channels 7, 9 and 11; selection written first
		bus(1'b1, CHANNEL_SELECT_LOW_ADDR, 16'h0080, 1'b0, q);
		bus(1'b1, CHANNEL_SELECT_HIGH_ADDR, 16'h000A, 1'b0, q);
		bus(1'b1, CONVERTER_CONTROL_ONE_ADDR, 16'h0001, 1'b0, q);
		for (int i = 0; i < 1000; i++) begin
			bus(1'b0, CONVERTER_CONTROL_ONE_ADDR, 16'h0000, 1'b0, q);
			if (q[0] === 1'b0) break;
		end
		check("run self clear", q, 16'h0000);
		repeat (20) @(posedge clock_in);
		check_starts(3, CONV_FAST_CYC, 1'b0, '{4'h7, 4'h9, 4'hB, 4'h0, 4'h0});
		check_results();
		// slow repeating pass over channels 8 and 10, stopped by software
		bus(1'b1, CONVERTER_CONTROL_ZERO_ADDR, 16'h0003, 1'b0, q);
		bus(1'b1, CHANNEL_SELECT_LOW_ADDR, 16'h0000, 1'b0, q);
		bus(1'b1, CHANNEL_SELECT_HIGH_ADDR, 16'h0005, 1'b0, q);
		// a wide write at control zero carries the run bit in its upper byte
		bus(1'b1, CONVERTER_CONTROL_ZERO_ADDR, 16'h0103, 1'b1, q);
		bus(1'b0, CONVERTER_CONTROL_ZERO_ADDR, 16'h0000, 1'b1, q);
		check("control wide", q, 16'h0103);
		for (int i = 0; i < 3000 && st_ch.size() < 5; i++) @(posedge clock_in);
		bus(1'b1, CONVERTER_CONTROL_ONE_ADDR, 16'h0000, 1'b0, q);
		repeat (500) @(posedge clock_in);
		bus(1'b0, CONVERTER_CONTROL_ONE_ADDR, 16'h0000, 1'b0, q);
		check("run after stop", q, 16'h0000);
		check_starts(5, CONV_SLOW_CYC, 1'b1, '{4'h8, 4'hA, 4'h8, 4'hA, 4'h8});
		check_results();
		// back-to-back reads stall the drain while the core floods channel 11
		ready_low_seen <= 1'b0;
		@(posedge clock_in);
		addr_in <= CH11_RESULT_LOW_ADDR;
		wide_in <= 1'b0;
		rd_in <= 1'b1;
		fork
			begin
				repeat (40) @(posedge clock_in);
				rd_in <= 1'b0;
			end
			begin
				repeat (20) partner.send(4'hB);
				partner.idle_line();
			end
		join
		repeat (30) @(posedge clock_in);
		check("buffer refused", {15'h0000, ready_low_seen}, 16'h0001);
		check("buffer drained", {15'h0000, res_ready_out}, 16'h0001);
		check_results();
		conclude();
	end
endmodule : tb_sar_adc_results_and_mode_control
`default_nettype wire
